// ==== common/blqp_pkg.sv ====
// Shared constants, types and helpers of the bulk list and done queue pointer bank.
package blqp_pkg;

  // ********************************************************************
  // Register map and field layout
  // ********************************************************************
  localparam int unsigned REG_AW        = 8;
  localparam logic [7:0]  BULK_HEAD_OFS = 8'h28;
  localparam logic [7:0]  BULK_CUR_OFS  = 8'h2C;
  localparam logic [7:0]  DONE_HEAD_OFS = 8'h30;
  localparam int unsigned PTR_LSB       = 4;
  localparam logic [31:0] PTR_MASK      = 32'hFFFFFFF0;
  localparam logic [31:0] PTR_RST       = 32'h00000000;
  localparam logic [31:0] NULL_PTR      = 32'h00000000;
  localparam logic [31:0] LINK_FIELD_OFS = 32'h00000008;

  // ********************************************************************
  // Done queue writer states
  // ********************************************************************
  typedef enum logic [2:0] {
    DQ_IDLE = 3'b001,
    DQ_LINK = 3'b010,
    DQ_SHARED_COMM_AREA = 3'b100
  } blqp_dq_state_t;

  // Clears the reserved low bits of a descriptor pointer.
  function automatic logic [31:0] blqp_ptr(input logic [31:0] v);
    return v & PTR_MASK;
  endfunction

endpackage

// ==== design/blqp_bulk_walk.sv ====
// Bulk current pointer that follows the bulk endpoint list.
`timescale 1ns/1ps
module blqp_bulk_walk
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        sw_wr_i,
  input  wire logic [31:0] sw_data_i,
  input  wire logic [31:0] head_i,
  input  wire logic        served_i,
  input  wire logic [31:0] next_i,
  input  wire logic        end_i,
  input  wire logic        filled_i,
  output logic      [31:0] cur_ff,
  output logic             filled_clr_ff
);
  import blqp_pkg::*;

  // Pointer update; nothing here reloads at a frame boundary, so the walk
  // resumes where it stopped.
  // resume not reload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_ff <= PTR_RST;
    end else if (end_i && filled_i) begin
      cur_ff <= blqp_ptr(head_i);
    end else if (served_i) begin
      cur_ff <= blqp_ptr(next_i);
    end else if (sw_wr_i) begin
      cur_ff <= blqp_ptr(sw_data_i);
    end
  end

  // Flag clear pulse goes out in the same edge as the reload lands.
  // flag clear pulsed on reload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filled_clr_ff <= 1'b0;
    end else begin
      filled_clr_ff <= end_i && filled_i;
    end
  end

endmodule

// ==== design/blqp_done_queue.sv ====
// Done queue head register and its memory write sequencer.
`timescale 1ns/1ps
module blqp_done_queue #(
  parameter logic [31:0] LINK_OFS = blqp_pkg::LINK_FIELD_OFS
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        sw_wr_i,
  input  wire logic [31:0] sw_data_i,
  input  wire logic        td_done_i,
  input  wire logic [31:0] td_addr_i,
  input  wire logic        shared_comm_area_req_i,
  input  wire logic [31:0] shared_comm_area_addr_i,
  input  wire logic        mem_ack_i,
  output logic             ready_ff,
  output logic             mem_wr_ff,
  output logic      [31:0] mem_addr_ff,
  output logic      [31:0] mem_data_ff,
  output logic      [31:0] head_ff
);
  import blqp_pkg::*;

  blqp_dq_state_t state_ff;
  blqp_dq_state_t nxt_state;
  logic [31:0]    td_ff;
  logic           pend_ff;
  logic           start;

  // Next state; a completion outranks a pending write-back.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DQ_IDLE: begin
        if (td_done_i) begin
          nxt_state = DQ_LINK;
        end else if (pend_ff) begin
          nxt_state = DQ_SHARED_COMM_AREA;
        end
      end
      DQ_LINK, DQ_SHARED_COMM_AREA: begin
        if (mem_ack_i) begin
          nxt_state = DQ_IDLE;
        end
      end
      default: nxt_state = DQ_IDLE;
    endcase
  end

  assign start = (state_ff == DQ_IDLE) && (nxt_state != DQ_IDLE);

  // State, ready and captured descriptor address.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= DQ_IDLE;
      ready_ff <= 1'b0;
      td_ff    <= NULL_PTR;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= (nxt_state == DQ_IDLE);
      if (state_ff == DQ_IDLE && td_done_i) begin
        td_ff <= td_addr_i;
      end
    end
  end

  // Write-back request waits here; a new request beats the clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= shared_comm_area_req_i || (pend_ff && !(start && nxt_state == DQ_SHARED_COMM_AREA));
    end
  end

  // Memory write port, held until acknowledged.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_wr_ff   <= 1'b0;
      mem_addr_ff <= NULL_PTR;
      mem_data_ff <= NULL_PTR;
    end else begin
      mem_wr_ff <= (nxt_state != DQ_IDLE);
      if (start) begin
        mem_addr_ff <= (nxt_state == DQ_LINK) ? td_addr_i + LINK_OFS : shared_comm_area_addr_i;
        mem_data_ff <= head_ff;
      end
    end
  end

  // Head register; hardware updates only land on an acknowledge.
  // low bits dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head_ff <= PTR_RST;
    end else if (state_ff == DQ_LINK && mem_ack_i) begin
      head_ff <= blqp_ptr(td_ff);
    end else if (state_ff == DQ_SHARED_COMM_AREA && mem_ack_i) begin
      head_ff <= NULL_PTR;
    end else if (sw_wr_i && state_ff == DQ_IDLE) begin
      head_ff <= blqp_ptr(sw_data_i);
    end
  end

endmodule

// ==== design/blqp_bank.sv ====
// Top of the bulk list and done queue pointer register bank.
`timescale 1ns/1ps

module blqp_bank #(
  parameter logic [31:0] LINK_OFS = blqp_pkg::LINK_FIELD_OFS
)
(
  input  wire logic                        CLOCK_I,
  input  wire logic                        RST_I,
  input  wire logic [blqp_pkg::REG_AW-1:0] REG_ADDR_I,
  input  wire logic                        REG_WR_I,
  input  wire logic                        REG_RD_I,
  input  wire logic [31:0]                 REG_WDATA_I,
  output logic      [31:0]                 REG_RDATA_O,
  output logic                             REG_RVALID_O,
  input  wire logic                        BULK_LIST_ENABLE_I,
  input  wire logic                        LIST_FILLED_FLAG_I,
  output logic                             LIST_FILLED_CLR_O,
  input  wire logic                        ED_SERVED_I,
  input  wire logic [31:0]                 NEXT_ED_ADDR_I,
  input  wire logic                        BULK_END_I,
  output logic      [31:0]                 BULK_CUR_ADDR_O,
  output logic      [31:0]                 BULK_HEAD_ADDR_O,
  input  wire logic                        TD_DONE_I,
  input  wire logic [31:0]                 TD_ADDR_I,
  output logic                             TD_READY_O,
  input  wire logic                        SHARED_COMM_AREA_WB_I,
  input  wire logic [31:0]                 SHARED_COMM_AREA_DONE_ADDR_I,
  output logic                             MEM_WR_O,
  output logic      [31:0]                 MEM_ADDR_O,
  output logic      [31:0]                 MEM_DATA_O,
  input  wire logic                        MEM_ACK_I,
  output logic      [31:0]                 DONE_HEAD_O
);
  import blqp_pkg::*;

  // ********************************************************************
  // Register write decode
  // ********************************************************************

  logic        head_wr;
  logic        cur_wr;
  logic        done_wr;
  logic [31:0] head_ff;
  logic        link_phase_ff;
  logic [31:0] link_td_ff;

  // Strobes per register; the current pointer only accepts software while
  // the bulk list is disabled, so the walk never races a driver write.
  assign head_wr = REG_WR_I && (REG_ADDR_I == BULK_HEAD_OFS);
  assign cur_wr  = REG_WR_I && (REG_ADDR_I == BULK_CUR_OFS) && !BULK_LIST_ENABLE_I;
  assign done_wr = REG_WR_I && (REG_ADDR_I == DONE_HEAD_OFS);

  // Bulk head pointer; reserved bits are forced low whatever is written.
  // reserved bits zero
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      head_ff <= PTR_RST;
    end else if (head_wr) begin
      head_ff <= blqp_ptr(REG_WDATA_I);
    end
  end

  // Head pointer mirrored to the list engine.
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      BULK_HEAD_ADDR_O <= PTR_RST;
    end else begin
      BULK_HEAD_ADDR_O <= head_ff;
    end
  end

  // ********************************************************************
  // Bulk list walk
  // ********************************************************************

  blqp_bulk_walk u_walk (
    .clk_i         (CLOCK_I),
    .rst_i         (RST_I),
    .sw_wr_i       (cur_wr),
    .sw_data_i     (REG_WDATA_I),
    .head_i        (head_ff),
    .served_i      (ED_SERVED_I),
    .next_i        (NEXT_ED_ADDR_I),
    .end_i         (BULK_END_I),
    .filled_i      (LIST_FILLED_FLAG_I),
    .cur_ff        (BULK_CUR_ADDR_O),
    .filled_clr_ff (LIST_FILLED_CLR_O)
  );

  // ********************************************************************
  // Done queue
  // ********************************************************************

  blqp_done_queue #(
    .LINK_OFS (LINK_OFS)
  ) u_done (
    .clk_i       (CLOCK_I),
    .rst_i       (RST_I),
    .sw_wr_i     (done_wr),
    .sw_data_i   (REG_WDATA_I),
    .td_done_i   (TD_DONE_I),
    .td_addr_i   (TD_ADDR_I),
    .shared_comm_area_req_i  (SHARED_COMM_AREA_WB_I),
    .shared_comm_area_addr_i (SHARED_COMM_AREA_DONE_ADDR_I),
    .mem_ack_i   (MEM_ACK_I),
    .ready_ff    (TD_READY_O),
    .mem_wr_ff   (MEM_WR_O),
    .mem_addr_ff (MEM_ADDR_O),
    .mem_data_ff (MEM_DATA_O),
    .head_ff     (DONE_HEAD_O)
  );

  // ********************************************************************
  // Register read
  // ********************************************************************

  // One cycle read latency; an unmapped offset reads as zero. The current
  // pointer is read live, so a read during a walk sees each advance.
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      REG_RDATA_O <= NULL_PTR;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        BULK_HEAD_OFS: REG_RDATA_O <= head_ff;
        BULK_CUR_OFS:  REG_RDATA_O <= BULK_CUR_ADDR_O;
        DONE_HEAD_OFS: REG_RDATA_O <= DONE_HEAD_O;
        default:       REG_RDATA_O <= NULL_PTR;
      endcase
    end
  end

  // Read valid strobe.
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
    end
  end

  // ********************************************************************
  // Checking
  // ********************************************************************

  // Tracks an accepted completion until its link write is acknowledged.
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      link_phase_ff <= 1'b0;
      link_td_ff    <= NULL_PTR;
    end else if (TD_DONE_I && TD_READY_O) begin
      link_phase_ff <= 1'b1;
      link_td_ff    <= TD_ADDR_I;
    end else if (MEM_WR_O && MEM_ACK_I) begin
      link_phase_ff <= 1'b0;
    end
  end

  AST_CUR_RSV: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    BULK_CUR_ADDR_O[PTR_LSB-1:0] == 4'h0
  ) else $error("Bulk current pointer reserved bits set.");

  AST_DONE_RSV: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    DONE_HEAD_O[PTR_LSB-1:0] == 4'h0
  ) else $error("Done head reserved bits set.");

  AST_ADVANCE: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    ED_SERVED_I && !(BULK_END_I && LIST_FILLED_FLAG_I)
    |=> BULK_CUR_ADDR_O == blqp_ptr($past(NEXT_ED_ADDR_I))
  ) else $error("Current pointer did not advance.");

  AST_RELOAD: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    BULK_END_I && LIST_FILLED_FLAG_I
    |=> BULK_CUR_ADDR_O == $past(head_ff) && LIST_FILLED_CLR_O
  ) else $error("List end with flag set did not reload.");

  AST_NO_FILL: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    BULK_END_I && !LIST_FILLED_FLAG_I && !ED_SERVED_I && !cur_wr
    |=> $stable(BULK_CUR_ADDR_O) && !LIST_FILLED_CLR_O
  ) else $error("List end with flag clear changed state.");

  AST_HOLD: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    !ED_SERVED_I && !BULK_END_I && !cur_wr
    |=> $stable(BULK_CUR_ADDR_O)
  ) else $error("Current pointer moved without cause.");

  AST_READ_LIVE: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    REG_RD_I && REG_ADDR_I == BULK_CUR_OFS
    |=> REG_RVALID_O && REG_RDATA_O == $past(BULK_CUR_ADDR_O)
  ) else $error("Current pointer read not live.");

  AST_RST_ZERO: assert property (
    @(posedge CLOCK_I)
    $past(RST_I) |-> BULK_CUR_ADDR_O == PTR_RST && DONE_HEAD_O == PTR_RST
  ) else $error("Pointers not zero after reset.");

  AST_LINK_DATA: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    TD_DONE_I && TD_READY_O
    |=> MEM_WR_O && MEM_DATA_O == $past(DONE_HEAD_O)
        && MEM_ADDR_O == $past(TD_ADDR_I) + LINK_OFS
  ) else $error("Link write carries wrong head or address.");

  AST_HEAD_LOAD: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    link_phase_ff && MEM_WR_O && MEM_ACK_I
    |=> DONE_HEAD_O == blqp_ptr($past(link_td_ff))
  ) else $error("Done head not loaded after link.");

  AST_ATOMIC: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    link_phase_ff |-> !TD_READY_O && $stable(DONE_HEAD_O)
  ) else $error("Completion accepted during link step.");

  AST_SHARED_COMM_AREA_CLR: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    !link_phase_ff && MEM_WR_O && MEM_ACK_I
    |=> DONE_HEAD_O == NULL_PTR
  ) else $error("Done head not cleared after copy.");

  AST_SHARED_COMM_AREA_WR: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    $rose(MEM_WR_O) && !link_phase_ff
    |-> MEM_ADDR_O == $past(SHARED_COMM_AREA_DONE_ADDR_I) && MEM_DATA_O == $past(DONE_HEAD_O)
  ) else $error("Shared area copy carries wrong data.");

  // Mirror of the head pointer trails the register by one cycle.
  AST_HEAD_MIRROR: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    !$past(RST_I) |-> BULK_HEAD_ADDR_O == $past(head_ff)
  ) else $error("Head pointer mirror out of step.");

  // A head write lands with its reserved bits cleared.
  AST_HEAD_WR: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    head_wr |=> head_ff == blqp_ptr($past(REG_WDATA_I))
  ) else $error("Head pointer write did not land.");

  // A driver write to the current pointer is dropped while the list runs.
  AST_CUR_LOCKED: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    REG_WR_I && REG_ADDR_I == BULK_CUR_OFS && BULK_LIST_ENABLE_I
    && !ED_SERVED_I && !BULK_END_I |=> $stable(BULK_CUR_ADDR_O)
  ) else $error("Current pointer written while list enabled.");

  // The flag clear pulse only follows a list end with the flag set.
  AST_CLR_CAUSE: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    LIST_FILLED_CLR_O |-> $past(BULK_END_I && LIST_FILLED_FLAG_I)
  ) else $error("Flag clear pulse without cause.");

  // Read valid only follows a read strobe.
  AST_RVALID_ONCE: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    !REG_RD_I |=> !REG_RVALID_O
  ) else $error("Read valid without a read.");

  // A pending memory write holds its address and data until acknowledged.
  AST_MEM_HOLD: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    MEM_WR_O && !MEM_ACK_I |=> MEM_WR_O && $stable(MEM_ADDR_O) && $stable(MEM_DATA_O)
  ) else $error("Memory write changed before acknowledge.");

  // Nothing but an acknowledge or a driver write moves the done head.
  AST_DONE_HOLD: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    !(MEM_WR_O && MEM_ACK_I) && !done_wr |=> $stable(DONE_HEAD_O)
  ) else $error("Done head moved without cause.");

endmodule

// ==== verif/blqp_mem_model.sv ====
// Memory model that acknowledges descriptor and shared area writes.
`timescale 1ns/1ps
module blqp_mem_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        mem_wr_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [31:0] mem_data_i,
  input  wire logic [3:0]  delay_i,
  output logic             mem_ack_o,
  output logic      [31:0] last_addr_o,
  output logic      [31:0] last_data_o
);
  logic [3:0] wait_ff;

  // Acknowledge after delay_i waiting cycles, so prompt and slow memory are both possible.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_ff     <= 4'h0;
      mem_ack_o   <= 1'b0;
      last_addr_o <= 32'h00000000;
      last_data_o <= 32'h00000000;
    end else if (mem_wr_i && !mem_ack_o) begin
      if (wait_ff == delay_i) begin
        wait_ff     <= 4'h0;
        mem_ack_o   <= 1'b1;
        last_addr_o <= mem_addr_i; // The write lands in memory here.
        last_data_o <= mem_data_i;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end else begin
      mem_ack_o <= 1'b0;
    end
  end
endmodule

// ==== verif/test_blqp_bank.sv ====
// Self-checking testbench of the bulk list and done queue pointer bank.
`timescale 1ns/1ps
module test_blqp_bank;
  import blqp_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} blqp_row_t;
  logic        clk, rst, wr, rd, bulk_list_enable, flag, served, bend, tdd, wb, ack;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, nxt, tda, hca, cur, head, mem_a, mem_d, dhead, ma, md;
  logic        rvalid, clr, rdy, mwr;
  logic [3:0]  dly;
  int          n_fail, checked, cyc;
  blqp_row_t   rows [4];

  blqp_bank DUT (.CLOCK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .BULK_LIST_ENABLE_I(bulk_list_enable),
    .LIST_FILLED_FLAG_I(flag), .LIST_FILLED_CLR_O(clr), .ED_SERVED_I(served),
    .NEXT_ED_ADDR_I(nxt), .BULK_END_I(bend), .BULK_CUR_ADDR_O(cur), .BULK_HEAD_ADDR_O(head),
    .TD_DONE_I(tdd), .TD_ADDR_I(tda), .TD_READY_O(rdy), .SHARED_COMM_AREA_WB_I(wb),
    .SHARED_COMM_AREA_DONE_ADDR_I(hca), .MEM_WR_O(mwr), .MEM_ADDR_O(mem_a), .MEM_DATA_O(mem_d),
    .MEM_ACK_I(ack), .DONE_HEAD_O(dhead));
  blqp_mem_model MEM (.clk_i(clk), .rst_i(rst), .mem_wr_i(mwr), .mem_addr_i(mem_a),
    .mem_data_i(mem_d), .delay_i(dly), .mem_ack_o(ack), .last_addr_o(ma), .last_data_o(md));

  // ********************************************************************
  // Clock, timeout and shared tasks
  // ********************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hung handshake must not stall the run forever.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked = checked + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Every task starts and ends just after a rising edge.
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr = a; wdata = d; wr = 1'b1;
    step();
    wr = 1'b0;
    step();
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    addr = a; rd = 1'b1;
    step();
    rd = 1'b0;
    chk({31'h0, rvalid}, 32'h1, "read valid");
    chk(rdata, e, "read data");
    step();
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    while (rdy !== 1'b1 && i < 40) begin
      step();
      i++;
    end
    chk({31'h0, rdy}, 32'h1, "ready");
  endtask

  task automatic td_done(input logic [31:0] t, input logic [31:0] old);
    wait_ready();
    tdd = 1'b1; tda = t;
    step();
    tdd = 1'b0;
    chk({31'h0, rdy}, 32'h0, "busy during link");
    step();
    wait_ready();
    chk({31'h0, mwr}, 32'h0, "write released");
    chk(ma, t + LINK_FIELD_OFS, "link address");
    chk(md, old, "link data");
    chk(dhead, t, "done head");
    $display("done queue completion test ended");
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    {wr, rd, bulk_list_enable, flag, served, bend, tdd, wb} = 8'h00;
    addr = 8'h00; wdata = 32'h0; nxt = 32'h0; tda = 32'h0; hca = 32'h0; dly = 4'h0;
    n_fail = 0; checked = 0; cyc = 0; rst = 1'b1;
    rows[0] = '{8'h28, 32'h3456789F, 32'h34567890};
    rows[1] = '{8'h2C, 32'h1234567F, 32'h12345670};
    rows[2] = '{8'h30, 32'h0ABCDEF5, 32'h0ABCDEF0};
    rows[3] = '{8'h34, 32'hFFFFFFFF, 32'h00000000};
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    step();
    chk(cur, PTR_RST, "current reset");
    reg_rd(BULK_CUR_OFS, 32'h0);
    reg_rd(DONE_HEAD_OFS, 32'h0);
    $display("reset test ended");
    // Software writes keep the reserved bits zero in every mapped row; the unmapped row reads back zero.
    foreach (rows[i]) begin
      reg_wr(rows[i].a, rows[i].w);
      reg_rd(rows[i].a, rows[i].e);
    end
    chk(head, 32'h34567890, "head mirror");
    $display("register table test ended");
    // Writes to the current pointer are ignored while the bulk list runs.
    bulk_list_enable = 1'b1;
    reg_wr(BULK_CUR_OFS, 32'h55555550);
    reg_rd(BULK_CUR_OFS, 32'h12345670);
    // Walk three descriptors back to back in insertion order.
    for (int i = 1; i <= 3; i++) begin
      served = 1'b1; nxt = 32'h00000100 * i + 32'h0000000C;
      step();
      chk(cur, 32'h00000100 * i, "advance");
    end
    served = 1'b0;
    reg_rd(BULK_CUR_OFS, 32'h00000300);
    // End of list with the flag clear changes nothing.
    bend = 1'b1;
    step();
    chk(cur, 32'h00000300, "end no flag");
    chk({31'h0, clr}, 32'h0, "no clear");
    flag = 1'b1;
    step();
    bend = 1'b0;
    chk(cur, 32'h34567890, "reload head");
    chk({31'h0, clr}, 32'h1, "clear pulse");
    flag = 1'b0;
    step();
    chk({31'h0, clr}, 32'h0, "clear once");
    $display("bulk walk test ended");
    // Completions with prompt and then slow memory.
    td_done(32'h00002000, 32'h0ABCDEF0);
    dly = 4'h3;
    td_done(32'h00002040, 32'h00002000);
    // Copy to the shared area, then the head empties.
    hca = 32'h00001084; wb = 1'b1;
    step();
    wb = 1'b0;
    step();
    wait_ready();
    chk(ma, 32'h00001084, "shared area address");
    chk(md, 32'h00002040, "shared area data");
    chk(dhead, NULL_PTR, "head cleared");
    reg_rd(DONE_HEAD_OFS, 32'h0);
    $display("shared area test ended");
    // A second reset in mid-run empties every pointer again.
    rst = 1'b1;
    repeat (2) step();
    rst = 1'b0;
    step();
    chk(cur, PTR_RST, "current second reset");
    chk(dhead, PTR_RST, "done head second reset");
    chk(head, PTR_RST, "mirror second reset");
    chk({31'h0, rdy}, 32'h1, "ready after reset");
    reg_rd(BULK_CUR_OFS, 32'h0);
    $display("second reset test ended");
    conclude();
  end
endmodule
